// File: verif/alk_access_power_properties.sv
`timescale 1ns/100ps
`default_nettype none
module alk_access_power_properties #(
  parameter SEC_CYCLES = 4
) (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic PROGRAM_KEY,
  input wire logic [3:0] FUNC_SEL,
  input wire logic FUNC_REQ,
  input wire logic HOST_ADDR_MATCH_REQ,
  input wire logic [7:0] HOST_ADDR,
  input wire logic MAINS_POWER,
  input wire logic SLEEP_WITH_DISPLAY,
  input wire logic CONFIG_MODE,
  input wire logic [7:0] UNIT_ADDRESS_VALUE,
  input wire logic [1:0] LOCK_CODE,
  input wire logic [7:0] DEVICE_IDLE_OFF_MINUTES,
  input wire logic [23:0] BAUD_RATE,
  input wire logic [2:0] SENSOR_LOCK_LEVEL,
  input wire logic ADDR_MATCH,
  input wire logic FUNC_GRANT,
  input wire logic FUNC_DENY,
  input wire logic VIEW_ACTIVE,
  input wire logic POWER_OFF,
  input wire logic BACKLIGHT_ON
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  a_baud_fixed: assert property (BAUD_RATE == 24'h002580)
    else $error("baud rate changed");
  a_addr_match: assert property (ADDR_MATCH == ($past(HOST_ADDR_MATCH_REQ, 2) &&
    $past(HOST_ADDR, 2) == UNIT_ADDRESS_VALUE)) else $error("address match wrong");
  a_cfg_refuse: assert property (FUNC_REQ && CONFIG_MODE && $past(CONFIG_MODE) &&
    !$past(PROGRAM_KEY) |-> ##2 FUNC_DENY) else $error("request served in menu");
  a_rel_nv_lock: assert property (FUNC_REQ && FUNC_SEL == 4'h8 &&
    (LOCK_CODE != 2'h0 || SENSOR_LOCK_LEVEL > 3'h4) |-> ##2 FUNC_DENY) else $error("rel nv");
  a_adj_nv_lock: assert property (FUNC_REQ && FUNC_SEL == 4'h9 &&
    (LOCK_CODE > 2'h1 || SENSOR_LOCK_LEVEL > 3'h5) |-> ##2 FUNC_DENY) else $error("adj nv");
  a_off_sticky: assert property (POWER_OFF |=> POWER_OFF)
    else $error("power off released");
  a_off_cause: assert property ($rose(POWER_OFF) |-> !$past(MAINS_POWER, 2) &&
    $past(DEVICE_IDLE_OFF_MINUTES, 2) != 8'h00) else $error("power off not allowed");
  a_sleep_dark: assert property (SLEEP_WITH_DISPLAY && $past(SLEEP_WITH_DISPLAY) &&
    $past(SLEEP_WITH_DISPLAY, 2) |-> !BACKLIGHT_ON) else $error("backlight in sleep");
  a_view_grant: assert property ($rose(VIEW_ACTIVE) |-> FUNC_GRANT)
    else $error("view without grant");
endmodule // alk_access_power_properties
bind alk_access_power alk_access_power_properties #(.SEC_CYCLES(SEC_CYCLES)) u_props (
  .MCLK(MCLK), .RST(RST), .PROGRAM_KEY(PROGRAM_KEY), .FUNC_SEL(FUNC_SEL), .FUNC_REQ(FUNC_REQ),
  .HOST_ADDR_MATCH_REQ(HOST_ADDR_MATCH_REQ), .HOST_ADDR(HOST_ADDR), .MAINS_POWER(MAINS_POWER),
  .SLEEP_WITH_DISPLAY(SLEEP_WITH_DISPLAY), .CONFIG_MODE(CONFIG_MODE), .LOCK_CODE(LOCK_CODE),
  .UNIT_ADDRESS_VALUE(UNIT_ADDRESS_VALUE), .DEVICE_IDLE_OFF_MINUTES(DEVICE_IDLE_OFF_MINUTES),
  .BAUD_RATE(BAUD_RATE), .SENSOR_LOCK_LEVEL(SENSOR_LOCK_LEVEL), .ADDR_MATCH(ADDR_MATCH),
  .FUNC_GRANT(FUNC_GRANT), .FUNC_DENY(FUNC_DENY), .VIEW_ACTIVE(VIEW_ACTIVE),
  .POWER_OFF(POWER_OFF), .BACKLIGHT_ON(BACKLIGHT_ON));
`default_nettype wire

// File: verif/alk_access_power_test.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
  $display("[ERR] %s expected %0h seen %0h", nm, e, g); end end
module alk_access_power_test;
  logic mclk, rst, req, mains, sleep, logging;
  logic [3:0] sel;
  logic [11:0] cfg_val, press;
  logic mem_k, fn_k, program_key_k, up_k, dn_k, any_k, q_req, l_we, cfg_mode, match, grant, deny;
  logic view, poff, bl;
  logic [2:0] l_in, item, slvl;
  logic [1:0] lock;
  logic [7:0] q_addr, addr, dev_min, bl_min;
  logic [23:0] baud;
  int n_errors = 0, comparisons = 0;
  alk_panel_host u_alk_panel_host (.clk(mclk), .mem_key(mem_k), .fn_key(fn_k),
    .program_key_key(program_key_k), .up_key(up_k), .down_key(dn_k), .any_key(any_k), .query_req(q_req),
    .query_addr(q_addr), .lock_we(l_we), .lock_in(l_in));
  alk_access_power #(.SEC_CYCLES(4)) u_alk_access_power (.MCLK(mclk), .RST(rst),
    .MEMORY_KEY(mem_k), .FUNCTION_KEY(fn_k), .PROGRAM_KEY(program_key_k), .UP_KEY(up_k),
    .DOWN_KEY(dn_k), .ANY_KEY(any_k), .FUNC_SEL(sel), .FUNC_REQ(req), .SENSOR_LOCK(3'h0),
    .SENSOR_LOCK_WE(l_we), .SENSOR_LOCK_IN(l_in), .LOGGING_ACTIVE(logging),
    .MAINS_POWER(mains), .SLEEP_WITH_DISPLAY(sleep), .HOST_ADDR_MATCH_REQ(q_req),
    .HOST_ADDR(q_addr), .CONFIG_MODE(cfg_mode), .CONFIG_ITEM(item), .CONFIG_VALUE(cfg_val),
    .UNIT_ADDRESS_VALUE(addr), .LOCK_CODE(lock), .DEVICE_IDLE_OFF_MINUTES(dev_min),
    .BACKLIGHT_IDLE_OFF_MINUTES(bl_min), .PRESSURE_MBAR(press), .BAUD_RATE(baud),
    .SENSOR_LOCK_LEVEL(slvl), .ADDR_MATCH(match), .FUNC_GRANT(grant), .FUNC_DENY(deny),
    .VIEW_ACTIVE(view), .POWER_OFF(poff), .BACKLIGHT_ON(bl));
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  task automatic wn(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic ask(input logic [3:0] f, input logic g, input string nm);
    @(negedge mclk);
    sel = f;
    req = 1'b1;
    @(negedge mclk);
    req = 1'b0;
    wn(1);
    `CHK(nm, g, grant)
    `CHK(nm, !g, deny)
  endtask
  // Boots into the menu and enters address, lock code and both idle limits
  task automatic cfg(input logic [7:0] a, input logic [1:0] lk, input logic [7:0] dm, bm);
    logic [7:0] v[4];
    v = '{a, {6'h00, lk}, dm, bm};
    rst = 1'b1;
    u_alk_panel_host.strap(1'b1);
    wn(16);
    rst = 1'b0;
    wn(3);
    u_alk_panel_host.strap(1'b0);
    `CHK("config_mode", 1'b1, cfg_mode)
    for (int i = 0; i < 4; i++) begin
      `CHK("config_item", i[2:0], item)
      repeat (v[i] + 1) u_alk_panel_host.tap(4'h2);
      u_alk_panel_host.tap(4'h1);
      wn(2);
      `CHK("config_value", {4'h0, v[i]}, cfg_val)
      u_alk_panel_host.tap(4'h8);
      wn(2);
    end
    `CHK("press_value", 12'h3f5, cfg_val)
    u_alk_panel_host.tap(4'h8);
    wn(2);
    `CHK("item_wrap", 3'h0, item)
    ask(4'h0, 1'b0, "menu_deny");
    u_alk_panel_host.tap(4'h4);
    wn(2);
    `CHK("config_end", 1'b0, cfg_mode)
    `CHK("address", a, addr)
    `CHK("lock_code", lk, lock)
    `CHK("dev_minutes", dm, dev_min)
    `CHK("bl_minutes", bm, bl_min)
    `CHK("baud", 24'h002580, baud)
    `CHK("pressure", 12'h3f5, press)
  endtask
  task automatic t_matrix;
    logic [13:0] m[4];
    m = '{14'h3fff, 14'h16fd, 14'h002d, 14'h000d};
    for (int c = 0; c < 4; c++) begin
      cfg(8'h01, c[1:0], 8'h00, 8'h00);
      for (int f = 0; f < 14; f++)
        ask(f[3:0], m[c][f], "matrix");
      if (c[0]) begin
        wn(130);
        ask(c[1] ? 4'h2 : 4'h6, 1'b1, "view_grant");
        wn(c[1] ? 34 : 114);
        `CHK("view_held", 1'b1, view)
        wn(14);
        `CHK("view_gone", 1'b0, view)
        ask(c[1] ? 4'h0 : 4'h2, 1'b1, "view_keep");
        wn(50);
        `CHK("view_kept", 1'b1, view)
      end
    end
    $display("matrix test done");
  endtask
  task automatic t_slock;
    cfg(8'h2a, 2'h0, 8'h00, 8'h00);
    u_alk_panel_host.query(8'h2a);
    wn(1);
    `CHK("match", 1'b1, match)
    u_alk_panel_host.query(8'h2b);
    wn(1);
    `CHK("no_match", 1'b0, match)
    u_alk_panel_host.set_lock(3'h5);
    ask(4'h8, 1'b0, "rel_nv");
    ask(4'h9, 1'b1, "adj_nv");
    ask(4'ha, 1'b0, "sens_view");
    ask(4'hb, 1'b0, "sens_program_key");
    logging = 1'b0;
    ask(4'hc, 1'b0, "log_view");
    ask(4'hd, 1'b0, "log_program_key");
    logging = 1'b1;
    `CHK("lock_level", 3'h5, slvl)
    u_alk_panel_host.set_lock(3'h4);
    ask(4'h8, 1'b1, "rel_nv");
    u_alk_panel_host.set_lock(3'h6);
    ask(4'h9, 1'b0, "adj_nv");
    $display("lock and address test done");
  endtask
  task automatic t_idle;
    cfg(8'h01, 2'h0, 8'h03, 8'h01);
    u_alk_panel_host.tap(4'h0);
    wn(3);
    `CHK("backlight", 1'b1, bl)
    sleep = 1'b1;
    wn(3);
    `CHK("bl_sleep", 1'b0, bl)
    sleep = 1'b0;
    mains = 1'b1;
    wn(800);
    `CHK("bl_mains", 1'b1, bl)
    `CHK("off_mains", 1'b0, poff)
    mains = 1'b0;
    u_alk_panel_host.tap(4'h0);
    wn(260);
    `CHK("bl_idle", 1'b0, bl)
    u_alk_panel_host.tap(4'h0);
    wn(3);
    `CHK("bl_back", 1'b1, bl)
    wn(465);
    `CHK("off_early", 1'b0, poff)
    wn(260);
    `CHK("off_late", 1'b1, poff)
    ask(4'h0, 1'b0, "off_deny");
    $display("idle test done");
  endtask
  task automatic close_out;
    $display("comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    req = 1'b0;
    sel = 4'h0;
    mains = 1'b0;
    sleep = 1'b0;
    logging = 1'b1;
    t_matrix;
    t_slock;
    t_idle;
    close_out;
  end
  initial begin
    wn(20000);
    n_errors++;
    close_out;
  end
endmodule // alk_access_power_test
`default_nettype wire

// File: verif/alk_panel_host.sv
`timescale 1ns/100ps
`default_nettype none
module alk_panel_host (
  input wire logic clk,
  output logic mem_key,
  output logic fn_key,
  output logic program_key_key,
  output logic up_key,
  output logic down_key,
  output logic any_key,
  output logic query_req,
  output logic [7:0] query_addr,
  output logic lock_we,
  output logic [2:0] lock_in
);
  // The power-on strap is left to the bench, which sets it before reset ends
  initial begin
    {fn_key, program_key_key, up_key, down_key, any_key} = 5'h00;
    query_req = 1'b0;
    query_addr = 8'h5a;
    lock_we = 1'b0;
    lock_in = 3'h2;
  end
  task automatic strap(input logic v);
    mem_key = v;
  endtask
  // Keys encoded fn, program_key, up, down; every press also counts as activity
  task automatic tap(input logic [3:0] k);
    @(negedge clk);
    {fn_key, program_key_key, up_key, down_key} = k;
    any_key = 1'b1;
    @(negedge clk);
    {fn_key, program_key_key, up_key, down_key} = 4'h0;
    any_key = 1'b0;
  endtask
  // Released lines show the inverse so a stale value is never mistaken for data
  task automatic query(input logic [7:0] a);
    @(negedge clk);
    query_req = 1'b1;
    query_addr = a;
    @(negedge clk);
    query_req = 1'b0;
    query_addr = ~a;
  endtask
  task automatic set_lock(input logic [2:0] v);
    @(negedge clk);
    lock_we = 1'b1;
    lock_in = v;
    @(negedge clk);
    lock_we = 1'b0;
    lock_in = ~v;
  endtask
endmodule // alk_panel_host
`default_nettype wire

// File: verilog/alk_access_power.v
`timescale 1ns/100ps
`default_nettype none
`include "alk_regs.vh"

module alk_access_power #(
  parameter SEC_CYCLES = `ALK_SEC_CYCLES
) (
  input wire MCLK,
  input wire RST,
  input wire MEMORY_KEY,
  input wire FUNCTION_KEY,
  input wire PROGRAM_KEY,
  input wire UP_KEY,
  input wire DOWN_KEY,
  input wire ANY_KEY,
  input wire [3:0] FUNC_SEL,
  input wire FUNC_REQ,
  input wire [2:0] SENSOR_LOCK,
  input wire SENSOR_LOCK_WE,
  input wire [2:0] SENSOR_LOCK_IN,
  input wire LOGGING_ACTIVE,
  input wire MAINS_POWER,
  input wire SLEEP_WITH_DISPLAY,
  input wire HOST_ADDR_MATCH_REQ,
  input wire [7:0] HOST_ADDR,
  output reg CONFIG_MODE,
  output reg [2:0] CONFIG_ITEM,
  output reg [11:0] CONFIG_VALUE,
  output reg [7:0] UNIT_ADDRESS_VALUE,
  output reg [1:0] LOCK_CODE,
  output reg [7:0] DEVICE_IDLE_OFF_MINUTES,
  output reg [7:0] BACKLIGHT_IDLE_OFF_MINUTES,
  output reg [11:0] PRESSURE_MBAR,
  output reg [23:0] BAUD_RATE,
  output reg [2:0] SENSOR_LOCK_LEVEL,
  output reg ADDR_MATCH,
  output reg FUNC_GRANT,
  output reg FUNC_DENY,
  output reg VIEW_ACTIVE,
  output reg POWER_OFF,
  output reg BACKLIGHT_ON
);
  localparam [1:0] ST_BOOT = 2'h0;
  localparam [1:0] ST_RUN = 2'h1;
  localparam [1:0] ST_CFG = 2'h2;
  localparam [1:0] ST_OFF = 2'h3;
  localparam [31:0] SEC_W = SEC_CYCLES;

  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg [31:0] sec_cnt_ff;
  reg [5:0] min_cnt_ff;
  reg sec_tick;
  reg minute_tick;
  reg [5:0] view_cnt_ff;
  reg view_on_ff;
  reg [5:0] view_lim_ff;
  reg [2:0] item_ff;
  reg [2:0] nxt_item;
  reg [7:0] addr_ff;
  reg [1:0] lock_ff;
  reg [7:0] devoff_ff;
  reg [7:0] bloff_ff;
  reg [11:0] press_ff;
  reg [2:0] slock_ff;
  reg key_d_ff;
  reg bl_off_ff;
  reg grant_ff;
  reg deny_ff;
  reg match_ff;
  wire key_edge;
  wire dev_expired;
  wire bl_expired;
  wire allow;
  wire [5:0] view_limit;

  // Permission matrix for a locking code, sensor lock and logger state
  function alk_allowed;
    input [3:0] fn;
    input [1:0] code;
    input [2:0] slock;
    input logging;
    begin
      case (fn)
        `ALK_FN_POINT: alk_allowed = 1'b1;
        `ALK_FN_DOUBLE: alk_allowed = (code == 2'h0);
        `ALK_FN_BATT: alk_allowed = 1'b1;
        `ALK_FN_EXTREME: alk_allowed = 1'b1;
        `ALK_FN_EXT_DEL: alk_allowed = (code <= 2'h1);
        `ALK_FN_MEM_SAVE: alk_allowed = (code <= 2'h2);
        `ALK_FN_MEM_VIEW: alk_allowed = (code <= 2'h1);
        `ALK_FN_REL_RAM: alk_allowed = (code <= 2'h1);
        `ALK_FN_REL_NV: alk_allowed = (code == 2'h0) && (slock <= `ALK_REL_LOCK_MAX);
        `ALK_FN_ADJ_NV: alk_allowed = (code <= 2'h1) && (slock <= `ALK_ADJ_LOCK_MAX);
        // Sensor lock levels above zero protect sensor functions from key access
        `ALK_FN_SENS_VIEW: alk_allowed = (code <= 2'h1) && (slock == 3'h0);
        `ALK_FN_SENS_PROGRAM_KEY: alk_allowed = (code == 2'h0) && (slock == 3'h0);
        `ALK_FN_LOG_VIEW: alk_allowed = logging && (code <= 2'h1);
        `ALK_FN_LOG_PROGRAM_KEY: alk_allowed = logging && (code == 2'h0);
        default: alk_allowed = 1'b0;
      endcase
    end
  endfunction

  assign key_edge = ANY_KEY && !key_d_ff;
  assign allow = alk_allowed(FUNC_SEL, lock_ff, slock_ff, LOGGING_ACTIVE);
  // Only battery/extremes at code 3 and memory view at code 1 time out; 0 keeps the view
  assign view_limit = (lock_ff == 2'h1 && FUNC_SEL == `ALK_FN_MEM_VIEW) ? 6'd30 :
    (lock_ff == 2'h3 && (FUNC_SEL == `ALK_FN_BATT || FUNC_SEL == `ALK_FN_EXTREME)) ? 6'd10 :
    6'd0;

  always @* begin
    sec_tick = (sec_cnt_ff == SEC_W - 32'h1);
    minute_tick = sec_tick && (min_cnt_ff == 6'd59);
  end

  always @* begin
    nxt_state = state_ff;
    nxt_item = item_ff;
    case (state_ff)
      ST_BOOT: begin
        nxt_state = MEMORY_KEY ? ST_CFG : ST_RUN;
        nxt_item = `ALK_ITEM_ADDR;
      end
      ST_RUN: begin
        if (dev_expired)
          nxt_state = ST_OFF;
      end
      ST_CFG: begin
        if (PROGRAM_KEY)
          nxt_state = ST_RUN;
        else if (FUNCTION_KEY)
          nxt_item = (item_ff == `ALK_ITEM_PRESS) ? `ALK_ITEM_ADDR : item_ff + 3'h1;
      end
      ST_OFF: nxt_state = ST_OFF;
      default: nxt_state = ST_RUN;
    endcase
  end

  alk_idle_timer u_dev_timer (
    .clk(MCLK),
    .rst(RST),
    .minute_tick(minute_tick),
    .restart(key_edge || state_ff != ST_RUN),
    .inhibit(MAINS_POWER),
    .limit_minutes(devoff_ff),
    .expired_ff(dev_expired)
  );

  alk_idle_timer u_bl_timer (
    .clk(MCLK),
    .rst(RST),
    .minute_tick(minute_tick),
    .restart(key_edge),
    .inhibit(MAINS_POWER),
    .limit_minutes(bloff_ff),
    .expired_ff(bl_expired)
  );

  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      state_ff <= ST_BOOT;
      item_ff <= `ALK_ITEM_ADDR;
      sec_cnt_ff <= 32'h0;
      min_cnt_ff <= 6'h00;
      view_cnt_ff <= 6'h00;
      view_lim_ff <= 6'h00;
      view_on_ff <= 1'b0;
      addr_ff <= `ALK_ADDR_DEFAULT;
      lock_ff <= `ALK_LOCK_DEFAULT;
      devoff_ff <= `ALK_DEV_OFF_DEFAULT;
      bloff_ff <= `ALK_BL_OFF_DEFAULT;
      press_ff <= `ALK_PRESS_DEFAULT;
      slock_ff <= 3'h0;
      key_d_ff <= 1'b0;
      bl_off_ff <= 1'b0;
      grant_ff <= 1'b0;
      deny_ff <= 1'b0;
      match_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      item_ff <= nxt_item;
      key_d_ff <= ANY_KEY;
      sec_cnt_ff <= sec_tick ? 32'h0 : sec_cnt_ff + 32'h1;
      if (sec_tick)
        min_cnt_ff <= (min_cnt_ff == 6'd59) ? 6'h00 : min_cnt_ff + 6'h01;
      if (SENSOR_LOCK_WE)
        slock_ff <= SENSOR_LOCK_IN;
      if (state_ff == ST_CFG && (UP_KEY || DOWN_KEY)) begin
        case (item_ff)
          `ALK_ITEM_ADDR: addr_ff <= UP_KEY ? addr_ff + 8'h01 : addr_ff - 8'h01;
          `ALK_ITEM_LOCK: lock_ff <= UP_KEY ? lock_ff + 2'h1 : lock_ff - 2'h1;
          `ALK_ITEM_DEVOFF: devoff_ff <= UP_KEY ? devoff_ff + 8'h01 : devoff_ff - 8'h01;
          `ALK_ITEM_BLOFF: bloff_ff <= UP_KEY ? bloff_ff + 8'h01 : bloff_ff - 8'h01;
          `ALK_ITEM_PRESS: press_ff <= UP_KEY ? press_ff + 12'h001 : press_ff - 12'h001;
          default: addr_ff <= addr_ff;
        endcase
      end
      // Only one networked unit answers: its own address must match
      match_ff <= HOST_ADDR_MATCH_REQ && (HOST_ADDR == addr_ff);
      grant_ff <= FUNC_REQ && state_ff == ST_RUN && allow;
      deny_ff <= FUNC_REQ && !(state_ff == ST_RUN && allow);
      // Limit is latched at grant so a later function select cannot change it
      if (FUNC_REQ && state_ff == ST_RUN && allow) begin
        view_cnt_ff <= 6'h00;
        view_lim_ff <= view_limit;
        view_on_ff <= 1'b1;
      end else if (view_on_ff && sec_tick && view_lim_ff != 6'h00) begin
        view_cnt_ff <= view_cnt_ff + 6'h01;
        if (view_cnt_ff + 6'h01 >= view_lim_ff)
          view_on_ff <= 1'b0;
      end
      if (key_edge)
        bl_off_ff <= 1'b0;
      else if (bl_expired)
        bl_off_ff <= 1'b1;
    end
  end

  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      CONFIG_MODE <= 1'b0;
      CONFIG_ITEM <= `ALK_ITEM_ADDR;
      CONFIG_VALUE <= 12'h000;
      UNIT_ADDRESS_VALUE <= `ALK_ADDR_DEFAULT;
      LOCK_CODE <= `ALK_LOCK_DEFAULT;
      DEVICE_IDLE_OFF_MINUTES <= `ALK_DEV_OFF_DEFAULT;
      BACKLIGHT_IDLE_OFF_MINUTES <= `ALK_BL_OFF_DEFAULT;
      PRESSURE_MBAR <= `ALK_PRESS_DEFAULT;
      BAUD_RATE <= `ALK_BAUD_DEFAULT;
      SENSOR_LOCK_LEVEL <= 3'h0;
      ADDR_MATCH <= 1'b0;
      FUNC_GRANT <= 1'b0;
      FUNC_DENY <= 1'b0;
      VIEW_ACTIVE <= 1'b0;
      POWER_OFF <= 1'b0;
      BACKLIGHT_ON <= 1'b0;
    end else begin
      CONFIG_MODE <= (state_ff == ST_CFG);
      CONFIG_ITEM <= item_ff;
      case (item_ff)
        `ALK_ITEM_ADDR: CONFIG_VALUE <= {4'h0, addr_ff};
        `ALK_ITEM_LOCK: CONFIG_VALUE <= {10'h000, lock_ff};
        `ALK_ITEM_DEVOFF: CONFIG_VALUE <= {4'h0, devoff_ff};
        `ALK_ITEM_BLOFF: CONFIG_VALUE <= {4'h0, bloff_ff};
        default: CONFIG_VALUE <= press_ff;
      endcase
      UNIT_ADDRESS_VALUE <= addr_ff;
      LOCK_CODE <= lock_ff;
      DEVICE_IDLE_OFF_MINUTES <= devoff_ff;
      BACKLIGHT_IDLE_OFF_MINUTES <= bloff_ff;
      PRESSURE_MBAR <= press_ff;
      BAUD_RATE <= `ALK_BAUD_DEFAULT;
      SENSOR_LOCK_LEVEL <= slock_ff;
      ADDR_MATCH <= match_ff;
      FUNC_GRANT <= grant_ff;
      FUNC_DENY <= deny_ff;
      VIEW_ACTIVE <= view_on_ff;
      POWER_OFF <= (state_ff == ST_OFF);
      BACKLIGHT_ON <= (state_ff != ST_OFF) && !bl_off_ff && !SLEEP_WITH_DISPLAY;
    end
  end
endmodule // alk_access_power

`default_nettype wire

// File: verilog/alk_idle_timer.v
`timescale 1ns/100ps
`default_nettype none
`include "alk_regs.vh"

// Minute counter of key inactivity; fires a level once the limit is reached.
module alk_idle_timer (
  input wire clk,
  input wire rst,
  input wire minute_tick,
  input wire restart,
  input wire inhibit,
  input wire [7:0] limit_minutes,
  output reg expired_ff
);
  reg [7:0] count_ff;
  reg [7:0] nxt_count;
  reg nxt_expired;

  always @* begin
    nxt_count = count_ff;
    nxt_expired = expired_ff;
    if (restart || inhibit || limit_minutes == `ALK_SETTING_NEVER) begin
      nxt_count = 8'h00;
      nxt_expired = 1'b0;
    end else if (minute_tick && !expired_ff) begin
      nxt_count = count_ff + 8'h01;
      if (count_ff + 8'h01 >= limit_minutes)
        nxt_expired = 1'b1;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      count_ff <= 8'h00;
      expired_ff <= 1'b0;
    end else begin
      count_ff <= nxt_count;
      expired_ff <= nxt_expired;
    end
  end
endmodule // alk_idle_timer

`default_nettype wire

// File: verilog/alk_regs.vh
`ifndef ALK_REGS_VH
`define ALK_REGS_VH

`define ALK_CLK_HZ 40000000
`define ALK_BAUD_DEFAULT 24'h002580
`define ALK_ADDR_DEFAULT 8'h00
`define ALK_LOCK_DEFAULT 2'h0
`define ALK_DEV_OFF_DEFAULT 8'h00
`define ALK_BL_OFF_DEFAULT 8'h00
`define ALK_PRESS_DEFAULT 12'h3f5
`define ALK_SETTING_NEVER 8'h00
`define ALK_MINUTE_S 60
`define ALK_VIEW_LIMIT3_S 10
`define ALK_VIEW_LIMIT1_S 30
`define ALK_SEC_CYCLES (`ALK_CLK_HZ * 1)
`define ALK_REL_LOCK_MAX 3'h4
`define ALK_ADJ_LOCK_MAX 3'h5

`define ALK_ITEM_ADDR 3'h0
`define ALK_ITEM_LOCK 3'h1
`define ALK_ITEM_DEVOFF 3'h2
`define ALK_ITEM_BLOFF 3'h3
`define ALK_ITEM_PRESS 3'h4

`define ALK_FN_POINT 4'h0
`define ALK_FN_DOUBLE 4'h1
`define ALK_FN_BATT 4'h2
`define ALK_FN_EXTREME 4'h3
`define ALK_FN_EXT_DEL 4'h4
`define ALK_FN_MEM_SAVE 4'h5
`define ALK_FN_MEM_VIEW 4'h6
`define ALK_FN_REL_RAM 4'h7
`define ALK_FN_REL_NV 4'h8
`define ALK_FN_ADJ_NV 4'h9
`define ALK_FN_SENS_VIEW 4'ha
`define ALK_FN_SENS_PROGRAM_KEY 4'hb
`define ALK_FN_LOG_VIEW 4'hc
`define ALK_FN_LOG_PROGRAM_KEY 4'hd

`endif
